//--- verilog/pmsfc_pkg.sv
// Purpose: Shared constants and types for the power-mode control block
// Assumes: 25 MHz system clock
// Notes: Register addresses are 7-bit serial-port addresses
package pmsfc_pkg;
	localparam logic [6:0] ADDR_CTRL = 7'h01;
	localparam logic [6:0] ADDR_EVENTS = 7'h0c;
	localparam logic [6:0] ADDR_MASK = 7'h0d;
	localparam logic [6:0] ADDR_KEY = 7'h10;
	localparam logic [6:0] ADDR_PROT_LO = 7'h11;
	localparam logic [6:0] ADDR_PROT_HI = 7'h27;
	localparam logic [6:0] ADDR_LAST = 7'h7f;
	localparam logic [7:0] KEY_FIRST = 8'hba;
	localparam logic [7:0] KEY_SECOND = 8'hbe;
	localparam logic [7:0] KEY_LOCKED = 8'h00;
	localparam logic [7:0] KEY_UNLOCKED = 8'h01;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'hdf;
	localparam logic [7:0] PROT_RESET = 8'h00;
	localparam int PROT_COUNT = 23;
	// Control bits
	localparam int CTRL_MIRROR_BIT = 0;
	localparam int CTRL_LED_BIT = 1;
	// Event bits
	localparam int EV_REG_FAULT = 0;
	localparam int EV_GATE_FAIL = 1;
	localparam int EV_LED_OVP = 2;
	localparam int EV_LS_FAIL = 3;
	localparam int EV_UVLO = 4;
	localparam int EV_TSD = 5;
	localparam int EV_SUPPLY_UV = 6;
	localparam int EV_COUNT = 7;
	// Interrupt re-assertion time after a read of a persisting fault
	localparam int REASSERT_US = 32;
	localparam int CLK_MHZ = 25;
	localparam int REASSERT_CYC = REASSERT_US * CLK_MHZ;
	localparam int REASSERT_W = 10;

	typedef enum logic [1:0] {
		PMSFC_OFF,
		PMSFC_STANDBY,
		PMSFC_MIRRORS_ONLY_STATE,
		PMSFC_MIRRORS_AND_LEDS_STATE
	} pmsfc_mode_t;

	typedef enum logic [1:0] {
		PMSFC_CMD,
		PMSFC_DATA
	} pmsfc_phase_t;

	typedef struct packed {
		logic regulator_fault;
		logic gate_rail_low;
		logic led_overvoltage;
		logic load_switch_low;
		logic input_uvlo;
		logic thermal_shutdown;
		logic supply_undervoltage;
	} pmsfc_faults_t;

	typedef struct packed {
		logic mirror_supply_on;
		logic led_supply_on;
		logic fast_discharge;
		logic internal_power_enable;
	} pmsfc_power_t;
endpackage : pmsfc_pkg

//--- verilog/pmsfc_ctrl.sv
// Purpose: Serial register port, unlock, event flags and mode machine
// Assumes: Serial clock is sampled by clk, well below clk/4
// Notes: One byte of shift per transfer step; MSB first
// What this block does
// - Regulator fault sets flag, clears mirror enable, shuts mirrors and LEDs down.
// - Gate rail low sets flag and stops LED converter; it retries itself.
// - LED overvoltage sets its flag; the LED converter keeps running.
// - Load switch collapse fast-discharges rails; only project_on toggle revives.
// - Every event sets its flag and pulls interrupt low unless masked.
// - Reading event_flags clears fault bits and releases the interrupt pin.
// - Persisting faults keep the flag and re-pull interrupt within 32 us.
// - Masked events still set flags and act; masking only gates the pin.
// - With select high, data input ignored and data output high impedance.
// - Sample input on serial clock rise; shift output on its fall.
// - First byte is command: bit 7 write when set, low 7 bits address.
// - Address increments per data byte, wrapping 0x7f to 0x00.
// - Addresses 0x11 to 0x27 read normally but ignore writes when locked.
// - Stays unlocked while writes to 0x10 are 0xba, or 0xbe right after 0xba; any other value locks.
// - Unlock register reads 0x00 when locked and 0x01 when unlocked.
// - project_on low means OFF: all off, defaults, no serial, reset_out low.
// - STANDBY on project_on rise, mirror enable cleared, or fault.
// - Mirrors on with enable; LEDs also on only with led enable.
// - Mirror enable defaults 0 at project_on rise, writable, fault clears.
// - Fault is any event except load switch, gate rail low, or LED overvoltage.
// - UVLO raises its event, powers rails down, clears enable, standby.
// - Thermal shutdown disables mirror and LED rails and sets thermal_shutdown_flag.
`timescale 1ns/1ps
module pmsfc_ctrl (
	input wire logic clk,
	input wire logic rst,
	input wire logic project_on_input,
	input wire logic serial_clk,
	input wire logic serial_select_n,
	input wire logic serial_din,
	output logic serial_dout,
	output logic serial_dout_oe_n,
	output logic interrupt_out_o,
	output logic interrupt_out_oe_n,
	input wire pmsfc_pkg::pmsfc_faults_t fault_in,
	output pmsfc_pkg::pmsfc_power_t power_out,
	output logic reset_out,
	output pmsfc_pkg::pmsfc_mode_t mode_out
);
	import pmsfc_pkg::*;

	typedef struct packed {
		logic [1:0] pon_s;
		logic [1:0] sck_s;
		logic [1:0] csn_s;
		logic [1:0] din_s;
		logic pon_q;
		logic sck_q;
		pmsfc_phase_t phase;
		logic [2:0] bitcnt;
		logic [7:0] shift_in;
		logic [7:0] shift_out;
		logic write_op;
		logic [6:0] addr;
		logic key_armed;
		logic unlocked;
		logic [7:0] ctrl;
		logic [7:0] mask;
		logic [EV_COUNT-1:0] flags;
		logic [REASSERT_W-1:0] reassert_cnt;
		logic ls_latched;
		pmsfc_mode_t mode;
		logic dout;
		logic dout_oe_n;
		logic int_oe_n;
		pmsfc_power_t power;
		logic rst_out;
		logic [PROT_COUNT-1:0][7:0] prot;
	} pmsfc_state_t;

	pmsfc_state_t s_q;
	pmsfc_state_t s_d;
	logic [EV_COUNT-1:0] ev_now;
	logic [7:0] rd_data;
	logic fault_any;
	logic [7:0] wbyte;
	logic [6:0] prot_idx;
	logic [6:0] rd_addr;
	logic [6:0] rd_idx;

	assign ev_now = {fault_in.supply_undervoltage, fault_in.thermal_shutdown,
		fault_in.input_uvlo, fault_in.load_switch_low,
		fault_in.led_overvoltage, fault_in.gate_rail_low,
		fault_in.regulator_fault};
	// Load switch collapse is deliberately not part of this OR
	assign fault_any = fault_in.regulator_fault | fault_in.supply_undervoltage
		| fault_in.thermal_shutdown | fault_in.input_uvlo;
	assign prot_idx = s_q.addr - ADDR_PROT_LO;
	// Read data is fetched a byte ahead: commanded address, then address + 1
	assign rd_addr = (s_q.phase == PMSFC_CMD)
		? {s_q.shift_in[5:0], s_q.din_s[1]} : s_q.addr + 7'd1;
	assign rd_idx = rd_addr - ADDR_PROT_LO;

	always_comb
	begin
		rd_data = 8'h00;
		if (rd_addr == ADDR_CTRL)
			rd_data = s_q.ctrl;
		else if (rd_addr == ADDR_EVENTS)
			rd_data = {1'b0, s_q.flags};
		else if (rd_addr == ADDR_MASK)
			rd_data = s_q.mask;
		else if (rd_addr == ADDR_KEY)
			rd_data = s_q.unlocked ? KEY_UNLOCKED : KEY_LOCKED;
		else if (rd_addr >= ADDR_PROT_LO && rd_addr <= ADDR_PROT_HI)
			rd_data = s_q.prot[rd_idx[4:0]];
	end

	always_comb
	begin
		logic sck_rise;
		logic sck_fall;
		logic byte_done;
		logic pon_rise;
		logic ev_read;
		logic [EV_COUNT-1:0] setmask;
		sck_rise = 1'b0;
		sck_fall = 1'b0;
		byte_done = 1'b0;
		pon_rise = 1'b0;
		ev_read = 1'b0;
		setmask = '0;
		wbyte = 8'h00;
		s_d = s_q;
		s_d.pon_s = {s_q.pon_s[0], project_on_input};
		s_d.sck_s = {s_q.sck_s[0], serial_clk};
		s_d.csn_s = {s_q.csn_s[0], serial_select_n};
		s_d.din_s = {s_q.din_s[0], serial_din};
		s_d.pon_q = s_q.pon_s[1];
		s_d.sck_q = s_q.sck_s[1];
		sck_rise = s_q.sck_s[1] & ~s_q.sck_q;
		sck_fall = ~s_q.sck_s[1] & s_q.sck_q;
		pon_rise = s_q.pon_s[1] & ~s_q.pon_q;

		// Serial port; select high resets the frame and floats output
		if (s_q.csn_s[1] || s_q.mode == PMSFC_OFF)
		begin
			s_d.phase = PMSFC_CMD;
			s_d.bitcnt = 3'd0;
			s_d.dout_oe_n = 1'b1;
			s_d.dout = 1'b0;
		end
		else
		begin
			s_d.dout_oe_n = 1'b0;
			if (sck_rise)
			begin
				s_d.shift_in = {s_q.shift_in[6:0], s_q.din_s[1]};
				s_d.bitcnt = s_q.bitcnt + 3'd1;
				byte_done = (s_q.bitcnt == 3'd7);
				wbyte = {s_q.shift_in[6:0], s_q.din_s[1]};
			end
			if (sck_fall)
			begin
				s_d.dout = s_q.shift_out[7];
				s_d.shift_out = {s_q.shift_out[6:0], 1'b0};
			end
		end

		if (byte_done && s_q.phase == PMSFC_CMD)
		begin
			s_d.write_op = wbyte[7];
			s_d.addr = wbyte[6:0];
			s_d.phase = PMSFC_DATA;
		end
		else if (byte_done)
		begin
			// Wrap comes free from the 7-bit counter
			s_d.addr = s_q.addr + 7'd1;
			if (s_q.write_op)
			begin
				if (s_q.addr == ADDR_KEY)
				begin
					// Second key only counts right after the first
					s_d.unlocked = (s_q.key_armed && wbyte == KEY_SECOND)
						|| (s_q.unlocked && wbyte == KEY_FIRST);
					s_d.key_armed = (wbyte == KEY_FIRST);
				end
				else
				begin
					s_d.key_armed = 1'b0;
					if (s_q.addr == ADDR_CTRL)
						s_d.ctrl = wbyte;
					else if (s_q.addr == ADDR_MASK)
						s_d.mask = wbyte;
					else if (s_q.addr >= ADDR_PROT_LO
						&& s_q.addr <= ADDR_PROT_HI && s_q.unlocked)
						s_d.prot[prot_idx[4:0]] = wbyte;
				end
			end
			else
			begin
				s_d.key_armed = 1'b0;
				ev_read = (s_q.addr == ADDR_EVENTS);
			end
		end
		// Next read byte loads at command end and after every byte
		if (byte_done)
			s_d.shift_out = rd_data;

		// Event flags: masked events still latch
		setmask = ev_now;
		if (ev_read)
			s_d.flags = setmask;
		else
			s_d.flags = s_q.flags | setmask;
		// Pin released on read, re-pulled after the wait if still unmasked
		if (ev_read)
		begin
			s_d.int_oe_n = 1'b1;
			// Count plus the compare stage makes the wait REASSERT_CYC - 1 cycles, one short of the full wait
			s_d.reassert_cnt = REASSERT_W'(REASSERT_CYC - 2);
		end
		else if (s_q.reassert_cnt != '0)
		begin
			s_d.reassert_cnt = s_q.reassert_cnt - 1'b1;
			// A fresh unmasked event pulls at once; only old ones wait
			if (|(ev_now & ~s_q.flags & ~s_q.mask[EV_COUNT-1:0]))
				s_d.int_oe_n = 1'b0;
		end
		else
			s_d.int_oe_n = ~|(s_q.flags & ~s_q.mask[EV_COUNT-1:0]);

		// Faults clear the mirror enable; project_on rise restores default
		if (pon_rise)
			s_d.ctrl[CTRL_MIRROR_BIT] = 1'b0;
		if (fault_any)
			s_d.ctrl[CTRL_MIRROR_BIT] = 1'b0;
		if (fault_in.load_switch_low)
			s_d.ls_latched = 1'b1;
		if (pon_rise)
			s_d.ls_latched = 1'b0;

		// Mode machine
		case (s_q.mode)
			PMSFC_OFF:
				if (s_q.pon_s[1])
					s_d.mode = PMSFC_STANDBY;
			default:
				if (fault_any || !s_q.ctrl[CTRL_MIRROR_BIT] || s_q.ls_latched)
					s_d.mode = PMSFC_STANDBY;
				else if (s_q.ctrl[CTRL_LED_BIT])
					s_d.mode = PMSFC_MIRRORS_AND_LEDS_STATE;
				else
					s_d.mode = PMSFC_MIRRORS_ONLY_STATE;
		endcase
		if (!s_q.pon_s[1])
		begin
			// OFF wipes registers but keeps the synchronisers
			s_d.mode = PMSFC_OFF;
			s_d.ctrl = CTRL_RESET;
			s_d.mask = MASK_RESET;
			s_d.flags = '0;
			s_d.unlocked = 1'b0;
			s_d.key_armed = 1'b0;
			s_d.int_oe_n = 1'b1;
			s_d.reassert_cnt = '0;
			s_d.prot = '0;
		end

		s_d.power.mirror_supply_on = (s_q.mode == PMSFC_MIRRORS_ONLY_STATE
			|| s_q.mode == PMSFC_MIRRORS_AND_LEDS_STATE)
			&& !fault_any && !fault_in.load_switch_low
			&& !s_q.ls_latched;
		// Gate rail low stalls LED converter only while low, so it retries
		s_d.power.led_supply_on = (s_q.mode == PMSFC_MIRRORS_AND_LEDS_STATE)
			&& !fault_any && !fault_in.gate_rail_low
			&& !fault_in.load_switch_low && !s_q.ls_latched;
		s_d.power.fast_discharge = s_q.ls_latched || fault_in.load_switch_low;
		s_d.power.internal_power_enable = (s_q.mode != PMSFC_OFF);
		s_d.rst_out = (s_q.mode != PMSFC_OFF);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_q <= '0;
			s_q.phase <= PMSFC_CMD;
			s_q.mode <= PMSFC_OFF;
			s_q.mask <= MASK_RESET;
			s_q.dout_oe_n <= 1'b1;
			s_q.int_oe_n <= 1'b1;
			s_q.csn_s <= 2'b11;
		end
		else
			s_q <= s_d;
	end

	assign serial_dout = s_q.dout;
	assign serial_dout_oe_n = s_q.dout_oe_n;
	assign interrupt_out_o = 1'b0;
	assign interrupt_out_oe_n = s_q.int_oe_n;
	assign power_out = s_q.power;
	assign reset_out = s_q.rst_out;
	assign mode_out = s_q.mode;
endmodule : pmsfc_ctrl

//--- testbench/pmsfc_ctrl_asserts.sv
// Purpose: Port checks for the power-mode control block
// Assumes: Interrupt mask left at its reset value
// Notes: Windows allow for the input synchronisers
`timescale 1ns/1ps
module pmsfc_chk
	import pmsfc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic project_on_input,
	input wire logic serial_clk,
	input wire logic serial_select_n,
	input wire logic serial_din,
	input wire logic serial_dout,
	input wire logic serial_dout_oe_n,
	input wire logic interrupt_out_o,
	input wire logic interrupt_out_oe_n,
	input wire pmsfc_pkg::pmsfc_faults_t fault_in,
	input wire pmsfc_pkg::pmsfc_power_t power_out,
	input wire logic reset_out,
	input wire pmsfc_pkg::pmsfc_mode_t mode_out
);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_idle;
		serial_select_n[*6];
	endsequence
	sequence s_off;
		!project_on_input[*6];
	endsequence
	a_sel_hiz: assert property (s_idle |-> serial_dout_oe_n)
		else $error("dout driven while deselected");
	a_off_reset: assert property (s_off |->
		!reset_out && mode_out == PMSFC_OFF)
		else $error("not off with pin low");
	a_led_mirror: assert property (power_out.led_supply_on |->
		power_out.mirror_supply_on)
		else $error("leds without mirrors");
	a_reg_fault: assert property (fault_in.regulator_fault |->
		##[1:4] !power_out.mirror_supply_on && !power_out.led_supply_on)
		else $error("regulator fault left supplies on");
	a_gate_low: assert property (fault_in.gate_rail_low |->
		##[1:3] !power_out.led_supply_on)
		else $error("led converter on with gate rail low");
	a_ovp_runs: assert property ($rose(fault_in.led_overvoltage) &&
		fault_in == 7'h10 && power_out.led_supply_on
		|=> power_out.led_supply_on[*3])
		else $error("overvoltage stopped leds");
	a_ls_dischg: assert property (fault_in.load_switch_low &&
		mode_out != PMSFC_OFF |-> ##[1:3] power_out.fast_discharge)
		else $error("no fast discharge");
	a_fault_stby: assert property ((fault_in[2:0] != 3'h0) &&
		mode_out != PMSFC_OFF |-> ##[1:4] mode_out == PMSFC_STANDBY)
		else $error("fault did not reach standby");
	a_tsd_irq: assert property ($rose(fault_in.thermal_shutdown) &&
		mode_out != PMSFC_OFF |-> ##[1:3] !interrupt_out_oe_n)
		else $error("unmasked event did not pull interrupt");
endmodule : pmsfc_chk
bind pmsfc_ctrl pmsfc_chk u_chk (.clk(clk), .rst(rst),
	.project_on_input(project_on_input), .serial_clk(serial_clk),
	.serial_select_n(serial_select_n), .serial_din(serial_din),
	.serial_dout(serial_dout), .serial_dout_oe_n(serial_dout_oe_n),
	.interrupt_out_o(interrupt_out_o),
	.interrupt_out_oe_n(interrupt_out_oe_n), .fault_in(fault_in),
	.power_out(power_out), .reset_out(reset_out), .mode_out(mode_out));

//--- testbench/pmsfc_host.sv
// Purpose: Host serial master model
// Assumes: Serial half period of four clk cycles, 320 ns period
// Notes: One or two data bytes per transfer
`timescale 1ns/1ps
module pmsfc_host (
	input wire logic clk,
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic dout
);
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
	end
	task automatic half;
		repeat (4) @(posedge clk);
		#1;
	endtask : half
	task automatic xfer(input logic [7:0] cmd, input int n,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [23:0] sh;
		sh = {cmd, wd};
		cs_n = 1'b0;
		for (int i = 0; i < 8 + 8 * n; i++)
		begin
			din = sh[23 - i];
			half();
			rd = {rd[14:0], dout};
			sclk = 1'b1;
			half();
			sclk = 1'b0;
		end
		cs_n = 1'b1;
		din = ~din; // No stale value once deselected
		half();
	endtask : xfer
endmodule : pmsfc_host

//--- testbench/pmsfc_ctrl_tb.sv
// Purpose: Self-checking bench for the power-mode control block
// Assumes: Host model drives the serial port
// Notes: Mask stays at reset value so only thermal events interrupt
`timescale 1ns/1ps
module pmsfc_ctrl_tb;
	import pmsfc_pkg::*;
	logic clk, rst, pon, sclk, cs_n, din, dout, doe_n, io, ioe_n, ro;
	pmsfc_faults_t flt;
	pmsfc_power_t pwr;
	pmsfc_mode_t mode;
	int miscompares = 0;
	int total_checks = 0;
	logic [15:0] rd;
	logic [7:0] d;
	pmsfc_ctrl uut (.clk(clk), .rst(rst), .project_on_input(pon),
		.serial_clk(sclk), .serial_select_n(cs_n), .serial_din(din),
		.serial_dout(dout), .serial_dout_oe_n(doe_n),
		.interrupt_out_o(io), .interrupt_out_oe_n(ioe_n), .fault_in(flt),
		.power_out(pwr), .reset_out(ro), .mode_out(mode));
	pmsfc_host host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din),
		.dout(doe_n ? ~dout : dout));
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic chk(input string s, input logic [7:0] g, e);
		total_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		host.xfer({1'b1, a}, 1, {v, 8'h00}, rd);
	endtask : wr
	task automatic rdb(input logic [6:0] a);
		host.xfer({1'b0, a}, 1, 16'h0000, rd);
		d = rd[7:0];
	endtask : rdb
	task automatic t_unlock;
		rdb(ADDR_KEY);
		chk("key", d, KEY_LOCKED);
		wr(ADDR_PROT_HI, 8'h5a);
		rdb(ADDR_PROT_HI);
		chk("locked", d, PROT_RESET);
		wr(ADDR_KEY, KEY_FIRST);
		wr(ADDR_KEY, KEY_SECOND);
		rdb(ADDR_KEY);
		chk("key", d, KEY_UNLOCKED);
		host.xfer({1'b1, ADDR_PROT_LO}, 2, 16'h3cc3, rd);
		host.xfer({1'b0, ADDR_PROT_LO}, 2, 16'h0000, rd);
		chk("burst0", rd[15:8], 8'h3c);
		chk("burst1", rd[7:0], 8'hc3);
		wr(ADDR_KEY, KEY_FIRST);
		rdb(ADDR_KEY);
		chk("key", d, KEY_UNLOCKED);
		wr(ADDR_KEY, 8'h33);
		rdb(ADDR_KEY);
		chk("key", d, KEY_LOCKED);
		$display("unlock done");
	endtask : t_unlock
	task automatic t_modes;
		for (int i = 0; i < 4; i++)
		begin
			wr(ADDR_CTRL, i[7:0]);
			cyc(4);
			chk("mode", {6'h0, mode}, i[0] ? (i[1] ? 8'h03 : 8'h02) : 8'h01);
		end
		rdb(ADDR_CTRL);
		chk("ctrl", d, 8'h03);
		$display("modes done");
	endtask : t_modes
	task automatic t_faults;
		flt.led_overvoltage = 1'b1;
		cyc(4);
		chk("ovp", {6'h0, mode}, 8'h03);
		flt.led_overvoltage = 1'b0;
		flt.gate_rail_low = 1'b1;
		cyc(4);
		chk("gate", {7'h0, pwr.led_supply_on}, 8'h00);
		flt.gate_rail_low = 1'b0;
		cyc(4);
		chk("retry", {7'h0, pwr.led_supply_on}, 8'h01);
		flt.regulator_fault = 1'b1;
		cyc(1);
		flt.regulator_fault = 1'b0;
		cyc(4);
		chk("regf", {6'h0, mode}, 8'h01);
		rdb(ADDR_CTRL);
		chk("enable", {7'h0, d[0]}, 8'h00);
		wr(ADDR_CTRL, 8'h03);
		cyc(4);
		chk("restart", {6'h0, mode}, 8'h03);
		for (int k = 0; k < 3; k += 2)
		begin
			flt[k] = 1'b1;
			cyc(4);
			flt[k] = 1'b0;
			chk("uv", {6'h0, mode}, 8'h01);
			wr(ADDR_CTRL, 8'h01);
		end
		chk("masked", {7'h0, ioe_n}, 8'h01);
		rdb(ADDR_EVENTS);
		chk("events", d, 8'h57);
		rdb(ADDR_EVENTS);
		chk("cleared", d, 8'h00);
		cyc(820);
		flt.thermal_shutdown = 1'b1;
		cyc(4);
		chk("irq", {7'h0, ioe_n}, 8'h00);
		chk("int_data", {7'h0, io}, 8'h00);
		chk("tsd", {7'h0, pwr.mirror_supply_on}, 8'h00);
		rdb(ADDR_EVENTS);
		chk("tsdflag", d, 8'h20);
		chk("release", {7'h0, ioe_n}, 8'h01);
		cyc(820);
		chk("repull", {7'h0, ioe_n}, 8'h00);
		rdb(ADDR_EVENTS);
		chk("persist", d, 8'h20);
		flt.thermal_shutdown = 1'b0;
		flt.load_switch_low = 1'b1;
		cyc(4);
		flt.load_switch_low = 1'b0;
		cyc(4);
		chk("dischg", {7'h0, pwr.fast_discharge}, 8'h01);
		$display("faults done");
	endtask : t_faults
	task automatic t_off;
		pon = 1'b0;
		cyc(8);
		chk("off", {5'h0, mode, ro}, 8'h00);
		chk("internal_power_enable", {7'h0, pwr.internal_power_enable}, 8'h00);
		pon = 1'b1;
		cyc(8);
		chk("on", {6'h0, mode}, 8'h01);
		chk("dischg", {7'h0, pwr.fast_discharge}, 8'h00);
		rdb(ADDR_CTRL);
		chk("ctrl", d, CTRL_RESET);
		$display("off done");
	endtask : t_off
	task automatic finish_test;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test
	initial
	begin
		#1000000;
		miscompares++;
		finish_test();
	end
	initial
	begin
		rst = 1'b1;
		pon = 1'b0;
		flt = '0;
		cyc(4);
		rst = 1'b0;
		cyc(4);
		chk("reset_out", {7'h0, ro}, 8'h00);
		pon = 1'b1;
		cyc(8);
		t_unlock();
		t_modes();
		t_faults();
		t_off();
		finish_test();
	end
endmodule : pmsfc_ctrl_tb
